//--- shared/wwdt_pkg.sv
// Purpose: Constants and types for the windowed watchdog timer
// Assumes: Core clock 125 MHz, low-power oscillator ticks as a strobe
// Notes:   Offsets, reset values and counts live here
package wwdt_pkg;

  // Core clock and nominal oscillator
  localparam int unsigned CORE_CLK_KHZ  = 125000;
  localparam int unsigned OSC_NOM_KHZ   = 32;
  // Prescale lengths
  localparam int unsigned PRE_SHORT_DIV = 32;
  localparam int unsigned PRE_LONG_DIV  = 128;
  localparam int unsigned PRE_W         = 7;
  // Base periods in microseconds
  localparam int unsigned BASE_SHORT_US = 1000;
  localparam int unsigned BASE_LONG_US  = 4000;
  // Postscale: 16 settings, 1:1 .. 1:32768
  localparam int unsigned POST_SEL_W    = 4;
  localparam int unsigned POST_W        = 15;
  localparam int unsigned POST_MAX_LOG2 = 15;
  // Core clocks per oscillator tick when generated internally
  localparam int unsigned OSC_DIV_CYC   = CORE_CLK_KHZ / OSC_NOM_KHZ;
  localparam int unsigned OSC_DIV_W     = 12;

  // Register map (byte offsets)
  localparam logic [7:0] REG_RESET_CTRL = 8'h00;
  localparam logic [7:0] REG_FUSE_WORD  = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT   = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK   = 8'h0c;
  localparam logic [7:0] REG_COUNT      = 8'h10;

  // Reset-control field positions
  localparam int unsigned RC_IDLE_BIT    = 2;
  localparam int unsigned RC_SLEEP_BIT   = 3;
  localparam int unsigned RC_TIMEOUT_BIT = 4;
  localparam int unsigned RC_SW_EN_BIT   = 5;
  // Fuse word field positions
  localparam int unsigned FW_POST_LSB    = 0;
  localparam int unsigned FW_PRE_BIT     = 4;
  localparam int unsigned FW_HW_EN_BIT   = 5;
  localparam int unsigned FW_WIN_DIS_BIT = 6;
  // Interrupt status bits
  localparam int unsigned IRQ_TIMEOUT    = 0;
  localparam int unsigned IRQ_WAKE       = 1;
  localparam int unsigned IRQ_EARLY_CLR  = 2;
  localparam int unsigned IRQ_W          = 3;

  localparam logic [31:0] RC_RESET   = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  typedef enum logic [1:0] {
    WWDT_RUN,
    WWDT_SAVE,
    WWDT_RST
  } wwdt_mode_e;

  typedef struct packed {
    logic                  hw_en;
    logic                  win_dis;
    logic                  pre_long;
    logic [POST_SEL_W-1:0] post_sel;
  } wwdt_fuse_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } wwdt_bus_s;

endpackage : wwdt_pkg

//--- verilog/wwdt_top.sv
// Purpose: Windowed watchdog timer with register port and interrupt
// Assumes: Core events are one-cycle pulses synchronous to i_core_clk
// Notes:   Oscillator ticks are generated from the core clock here
`timescale 1ns/1ps
module wwdt_top
  import wwdt_pkg::*;
#(
  parameter int unsigned OSC_DIV = OSC_DIV_CYC
) (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  // Fuse word
  input  wire logic [7:0]  i_fuse_word,
  // Core events
  input  wire logic        i_clear_instr,
  input  wire logic        i_sleep_enter,
  input  wire logic        i_idle_enter,
  input  wire logic        i_save_exit,
  input  wire logic        i_clk_switch_done,
  input  wire logic        i_device_reset,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output      logic [31:0] o_rdata,
  // Outputs
  output      logic        o_wdt_reset,
  output      logic        o_wake,
  output      logic        o_osc_en,
  output      logic        o_irq
);

  initial begin
    if (OSC_DIV < 2 || OSC_DIV >= (1 << OSC_DIV_W)) begin
      $error("OSC_DIV out of range");
    end
  end

  typedef struct packed {
    logic [OSC_DIV_W-1:0]  osc_cnt;
    logic                  tick;
    logic [PRE_W-1:0]      pre;
    logic [POST_W-1:0]     post;
    wwdt_mode_e            mode;
    logic                  sw_en;
    logic                  tmo_flag;
    logic                  sleep_f;
    logic                  idle_f;
    logic [IRQ_W-1:0]      stat;
    logic [IRQ_W-1:0]      mask;
    logic [31:0]           rdata;
    logic                  wdt_reset;
    logic                  wake;
    logic                  osc_en;
    logic                  irq;
  } wwdt_state_s;

  wwdt_state_s st_q;
  wwdt_state_s st_d;
  wwdt_fuse_s  fuse;
  wwdt_bus_s   bus;

  assign fuse.hw_en    = i_fuse_word[FW_HW_EN_BIT];
  assign fuse.win_dis  = i_fuse_word[FW_WIN_DIS_BIT];
  assign fuse.pre_long = i_fuse_word[FW_PRE_BIT];
  assign fuse.post_sel = i_fuse_word[FW_POST_LSB +: POST_SEL_W];
  assign bus.wr        = i_wr;
  assign bus.rd        = i_rd;
  assign bus.addr      = i_addr;
  assign bus.wdata     = i_wdata;

  // Postscale terminal value for a 2^sel division
  function automatic logic [POST_W-1:0] post_last(
    input logic [POST_SEL_W-1:0] sel
  );
    logic [POST_W:0] one;
    one = {{POST_W{1'b0}}, 1'b1};
    post_last = POST_W'((one << sel) - 1'b1);
  endfunction : post_last

  logic                 enabled;
  logic                 pre_wrap;
  logic                 post_wrap;
  logic                 timeout;
  logic                 in_window;
  logic                 early_clr;
  logic                 restart;
  logic [PRE_W-1:0]     pre_last;
  logic [POST_W-1:0]    p_last;
  logic [IRQ_W-1:0]     ev;

  always_comb begin
    st_d = st_q;
    // Hardware enable overrides software bit
    enabled  = fuse.hw_en | st_q.sw_en;
    pre_last = fuse.pre_long ? PRE_W'(PRE_LONG_DIV - 1)
                             : PRE_W'(PRE_SHORT_DIV - 1);
    p_last   = post_last(fuse.post_sel);
    // Compare at or above so a shorter setting never lets a count run past
    pre_wrap  = enabled & st_q.tick & (st_q.pre >= pre_last);
    post_wrap = pre_wrap & (st_q.post >= p_last);
    timeout   = post_wrap;
    // Last quarter of the postscaled period; 1:1 and 1:2 use the last quarter of the final prescale period
    if (fuse.post_sel < POST_SEL_W'(2)) begin
      in_window = ({st_q.post, st_q.pre} >=
                   {p_last, PRE_W'(pre_last - (pre_last >> 2))});
    end else begin
      in_window = (st_q.post >= (p_last - (p_last >> 2)));
    end
    early_clr = enabled & i_clear_instr & ~fuse.win_dis
              & ~in_window & (st_q.mode == WWDT_RUN);
    restart = i_clk_switch_done | i_clear_instr
            | i_sleep_enter | i_idle_enter | i_save_exit;
    ev = '0;
    st_d.wdt_reset = 1'b0;
    st_d.wake      = 1'b0;
    // Free oscillator, gated by enable
    st_d.osc_en = enabled;
    st_d.tick   = 1'b0;
    if (!enabled) begin
      st_d.osc_cnt = '0;
    end else if (st_q.osc_cnt == OSC_DIV_W'(OSC_DIV - 1)) begin
      st_d.osc_cnt = '0;
      st_d.tick    = 1'b1;
    end else begin
      st_d.osc_cnt = st_q.osc_cnt + 1'b1;
    end
    // Counter chain
    if (restart || !enabled) begin
      st_d.pre  = '0;
      st_d.post = '0;
    end else if (pre_wrap) begin
      st_d.pre  = '0;
      st_d.post = post_wrap ? '0 : st_q.post + 1'b1;
    end else if (enabled && st_q.tick) begin
      st_d.pre = st_q.pre + 1'b1;
    end
    // Mode tracking
    case (st_q.mode)
      WWDT_RUN: begin
        if (i_sleep_enter || i_idle_enter) begin
          st_d.mode = WWDT_SAVE;
        end
      end
      WWDT_SAVE: begin
        if (i_save_exit) begin
          st_d.mode = WWDT_RUN;
        end
      end
      WWDT_RST: begin
        st_d.mode = WWDT_RUN;
      end
      default: st_d.mode = WWDT_RUN;
    endcase
    if (i_sleep_enter) begin
      st_d.sleep_f = 1'b1;
    end
    if (i_idle_enter) begin
      st_d.idle_f = 1'b1;
    end
    // Time-out handling
    if (timeout && !restart) begin
      st_d.tmo_flag = 1'b1;
      ev[IRQ_TIMEOUT] = 1'b1;
      if (st_q.mode == WWDT_SAVE) begin
        st_d.wake = 1'b1;
        st_d.mode = WWDT_RUN;
        ev[IRQ_WAKE] = 1'b1;
      end else begin
        st_d.wdt_reset = 1'b1;
        st_d.mode      = WWDT_RST;
      end
    end
    if (early_clr) begin
      st_d.wdt_reset = 1'b1;
      st_d.mode      = WWDT_RST;
      ev[IRQ_EARLY_CLR] = 1'b1;
    end
    // Register writes; hardware set wins over software clear
    if (bus.wr && bus.addr == REG_RESET_CTRL) begin
      st_d.sw_en    = bus.wdata[RC_SW_EN_BIT];
      st_d.tmo_flag = bus.wdata[RC_TIMEOUT_BIT]
                    | st_d.tmo_flag & (timeout & ~restart);
      st_d.sleep_f  = bus.wdata[RC_SLEEP_BIT] | i_sleep_enter;
      st_d.idle_f   = bus.wdata[RC_IDLE_BIT] | i_idle_enter;
    end
    if (bus.wr && bus.addr == REG_IRQ_MASK) begin
      st_d.mask = bus.wdata[IRQ_W-1:0];
    end
    // Reads: status cleared on read, new events kept
    st_d.rdata = '0;
    if (bus.rd) begin
      case (bus.addr)
        REG_RESET_CTRL: begin
          st_d.rdata[RC_SW_EN_BIT]   = st_q.sw_en;
          st_d.rdata[RC_TIMEOUT_BIT] = st_q.tmo_flag;
          st_d.rdata[RC_SLEEP_BIT]   = st_q.sleep_f;
          st_d.rdata[RC_IDLE_BIT]    = st_q.idle_f;
        end
        REG_FUSE_WORD: st_d.rdata[7:0] = i_fuse_word;
        REG_IRQ_STAT: begin
          st_d.rdata[IRQ_W-1:0] = st_q.stat;
          st_d.stat = '0;
        end
        REG_IRQ_MASK:  st_d.rdata[IRQ_W-1:0] = st_q.mask;
        REG_COUNT:     st_d.rdata = {10'h000, st_q.post, st_q.pre};
        default:       st_d.rdata = '0;
      endcase
    end
    st_d.stat = st_d.stat | ev;
    st_d.irq  = |(st_d.stat & st_d.mask);
    // Device reset clears counters and software enable
    if (i_device_reset) begin
      st_d.pre   = '0;
      st_d.post  = '0;
      st_d.sw_en = 1'b0;
      st_d.osc_cnt = '0;
      st_d.mode  = WWDT_RUN;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_rdata     = st_q.rdata;
  assign o_wdt_reset = st_q.wdt_reset;
  assign o_wake      = st_q.wake;
  assign o_osc_en    = st_q.osc_en;
  assign o_irq       = st_q.irq;

  // Assertions
  sequence s_timeout_run;
    timeout && !restart && st_q.mode == WWDT_RUN && !early_clr;
  endsequence

  a_timeout_resets: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    s_timeout_run |=> o_wdt_reset && st_q.tmo_flag)
    else $error("Run time-out did not reset");

  a_sleep_wakes: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    timeout && !restart && st_q.mode == WWDT_SAVE |=> o_wake && !o_wdt_reset)
    else $error("Save time-out did not wake");

  a_early_clear: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    early_clr |=> o_wdt_reset ##1 !o_wdt_reset)
    else $error("Early clear missed reset");

  a_window_off: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_clear_instr && fuse.win_dis && !timeout |=> !o_wdt_reset
      && st_q.pre == '0 && st_q.post == '0)
    else $error("Clear with window off misbehaved");

  a_switch_clears: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_clk_switch_done |=> st_q.pre == '0 && st_q.post == '0)
    else $error("Clock switch did not clear");

  a_save_clears: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_sleep_enter || i_save_exit |=> st_q.pre == '0 && st_q.post == '0)
    else $error("Power save did not clear");

  a_reset_swen: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_device_reset |=> !st_q.sw_en && st_q.pre == '0)
    else $error("Device reset left state");

  a_flag_sticky: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    st_q.tmo_flag && !(bus.wr && bus.addr == REG_RESET_CTRL)
      |=> st_q.tmo_flag)
    else $error("Time-out flag dropped");

  a_osc_follows: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    fuse.hw_en ##1 fuse.hw_en |-> o_osc_en)
    else $error("Oscillator not enabled");

  a_pre_bound: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    !fuse.pre_long && st_q.pre <= pre_last ##1 !fuse.pre_long
      |-> st_q.pre <= pre_last)
    else $error("Prescaler overran");

endmodule : wwdt_top

//--- verification/wwdt_top_bench.sv
// Purpose: Self-checking bench for the windowed watchdog timer
// Assumes: Short oscillator divider so each time-out takes few cycles
// Notes:   Periods checked to within two oscillator ticks of phase
`timescale 1ns/1ps
module wwdt_top_bench
  import wwdt_pkg::*;
;
  localparam int OSC_D = 4;
  localparam int RS[3] = '{0, 4, 5};
  logic        i_core_clk;
  logic        i_rstn;
  logic [7:0]  i_fuse_word;
  logic [5:0]  ev;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic        o_wdt_reset;
  logic        o_wake;
  logic        o_osc_en;
  logic        o_irq;
  int          fails;
  int          n_compared;
  logic [31:0] lfsr_q;

  wwdt_top #(.OSC_DIV(OSC_D)) wwdt_top_inst (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_fuse_word(i_fuse_word),
    .i_clear_instr(ev[0]), .i_sleep_enter(ev[1]), .i_idle_enter(ev[2]),
    .i_save_exit(ev[3]), .i_clk_switch_done(ev[4]), .i_device_reset(ev[5]),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_wdt_reset(o_wdt_reset), .o_wake(o_wake),
    .o_osc_en(o_osc_en), .o_irq(o_irq));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  // Model of the time-out length in core cycles
  function automatic int per(input logic pl, input logic [3:0] s);
    return (pl ? PRE_LONG_DIV : PRE_SHORT_DIV) * (1 << s) * OSC_D;
  endfunction : per

  function automatic logic [7:0] fw(input logic hw, wd, pl,
                                    input logic [3:0] s);
    return {1'b0, wd, hw, pl, s};
  endfunction : fw

  task automatic close_out();
    $display("Compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    @(negedge i_core_clk);
    chk(o_rdata & m, e);
  endtask : rd

  task automatic pulse(input int k);
    @(posedge i_core_clk);
    ev <= 6'h1 << k;
    @(posedge i_core_clk);
    ev <= 6'h0;
  endtask : pulse

  // Fuse changes land just after a rising edge
  task automatic set_fuse(input logic [7:0] f);
    @(posedge i_core_clk);
    i_fuse_word <= f;
  endtask : set_fuse

  // No reset request may appear while waiting
  task automatic quiet(input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      @(negedge i_core_clk);
      if (o_wdt_reset !== 1'b0) bad++;
    end
    chk(bad, 0);
  endtask : quiet

  // Bounded wait for a reset (w=0) or wake (w=1) pulse
  task automatic wait_evt(input logic w, input int t);
    int n;
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < t + 4 * OSC_D) begin
      @(negedge i_core_clk);
      n++;
      hit = ((w ? o_wake : o_wdt_reset) === 1'b1);
    end
    chk(hit, 1'b1);
    chk(n > t - 2 * OSC_D && n < t + 2 * OSC_D, 1'b1);
  endtask : wait_evt

  initial begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end

  // Whole run is under ten thousand cycles
  initial begin
    #200000;
    fails++;
    close_out();
  end

  initial begin
    int t;
    i_rstn = 1'b0;
    i_fuse_word = fw(1'b0, 1'b1, 1'b0, 4'h0);
    ev = 6'h0;
    i_addr = 8'h0;
    i_wdata = 32'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    fails = 0;
    n_compared = 0;
    lfsr_q = 32'h68de;
    t = per(1'b0, 4'h0);
    repeat (8) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    rd(REG_RESET_CTRL, 32'h0, '1);
    rd(REG_FUSE_WORD, {24'h0, i_fuse_word}, '1);
    quiet(3 * t);
    chk(o_osc_en, 1'b0);
    wr(REG_RESET_CTRL, 32'h20);
    wr(REG_IRQ_MASK, 32'h1);
    wait_evt(1'b0, t);
    chk(o_osc_en, 1'b1);
    rd(REG_RESET_CTRL, 32'h30, '1);
    chk(o_irq, 1'b1);
    rd(REG_IRQ_STAT, 32'h1, 32'h1);
    @(negedge i_core_clk);
    chk(o_irq, 1'b0);
    pulse(5);
    rd(REG_RESET_CTRL, 32'h10, '1);
    quiet(3 * t);
    wr(REG_RESET_CTRL, 32'h0);
    rd(REG_RESET_CTRL, 32'h0, '1);
    repeat (4) begin
      lfsr_q = lfsr(lfsr_q);
      wr(REG_IRQ_MASK, lfsr_q);
      rd(REG_IRQ_MASK, {29'h0, lfsr_q[2:0]}, '1);
      wr(REG_FUSE_WORD, lfsr_q);
      rd(REG_FUSE_WORD, {24'h0, i_fuse_word}, '1);
      wr(8'h40 | lfsr_q[5:0], lfsr_q);
      rd(8'h40 | lfsr_q[5:0], 32'h0, '1);
    end
    for (int pl = 0; pl < 2; pl++) begin
      for (int s = 0; s < 3; s++) begin
        set_fuse(fw(1'b1, 1'b1, pl[0], s[3:0]));
        pulse(5);
        wait_evt(1'b0, per(pl[0], s[3:0]));
      end
    end
    set_fuse(fw(1'b1, 1'b1, 1'b0, 4'h0));
    for (int i = 0; i < 3; i++) begin
      pulse(5);
      repeat (3) begin
        quiet(t / 2);
        pulse(RS[i]);
      end
      wait_evt(1'b0, t);
    end
    wr(REG_IRQ_MASK, 32'h2);
    for (int k = 1; k < 3; k++) begin
      pulse(5);
      quiet(t / 2);
      pulse(k);
      wait_evt(1'b1, t);
      pulse(3);
      wait_evt(1'b0, t);
      chk(o_irq, 1'b1);
      rd(REG_IRQ_STAT, 32'h2, 32'h2);
      rd(REG_RESET_CTRL, 32'h1 << (k == 1 ? 3 : 2), 32'hc);
      wr(REG_RESET_CTRL, 32'h0);
      rd(REG_RESET_CTRL, 32'h0, 32'hc);
    end
    // Window mode: early clear punished, late clear accepted
    set_fuse(fw(1'b1, 1'b0, 1'b0, 4'h0));
    pulse(5);
    quiet(t / 4);
    pulse(0);
    wait_evt(1'b0, 1);
    pulse(5);
    quiet(t * 7 / 8);
    pulse(0);
    wait_evt(1'b0, t);
    close_out();
  end
endmodule : wwdt_top_bench
